// ===== hsf_fault_ctrl.sv
// Fault handling controller of a single-channel high-side switch.
// Assumes pins and comparator flags are asynchronous; all are synchronised here.
`timescale 1ns/1ps
module hsf_fault_ctrl #(
  parameter int RETRY_CYC = hsf_pkg::RETRY_CYC, // Retry interval in cycles
  parameter bit FOLDBACK = 1'b1                 // Foldback variant when set
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Controller pins
  input wire logic i_enable,
  input wire logic i_hold,
  // Temperatures
  input wire logic [hsf_pkg::TEMP_W-1:0] i_transistor_junction_temp,
  input wire logic [hsf_pkg::TEMP_W-1:0] i_controller_temp,
  input wire logic [hsf_pkg::TEMP_W-1:0] i_absolute_temp_limit,
  input wire logic [hsf_pkg::TEMP_W-1:0] i_relative_temp_limit,
  input wire logic [hsf_pkg::TEMP_W-1:0] i_thermal_hysteresis,
  // Current limit comparator and setting
  input wire logic i_overcurrent,
  input wire logic [hsf_pkg::LIM_W-1:0] i_current_limit_setting,
  // Output stage and sense output
  output logic o_gate_on,
  output logic [1:0] o_sense_output,
  output logic [hsf_pkg::LIM_W-1:0] o_current_limit_threshold,
  output logic o_fault,
  output logic o_foldback
);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  // The limit setting is a pin level too, so it shares the same chain
  localparam int SW = 3 + 5 * hsf_pkg::TEMP_W + hsf_pkg::LIM_W;
  logic [SW-1:0] sync1_reg, sync2_reg; // Two-flop chain, first stage read only by second
  logic en_s, hold_s, oc_s;
  logic [hsf_pkg::TEMP_W-1:0] tj_s, tc_s, tabs_s, trel_s, thys_s;
  logic [hsf_pkg::LIM_W-1:0] lim_s;   // Synchronised nominal limit code

  // Bring every pin into the clock domain
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {i_enable, i_hold, i_overcurrent, i_transistor_junction_temp,
                    i_controller_temp, i_absolute_temp_limit, i_relative_temp_limit,
                    i_thermal_hysteresis, i_current_limit_setting};
      sync2_reg <= sync1_reg;
    end
  end

  assign {en_s, hold_s, oc_s, tj_s, tc_s, tabs_s, trel_s, thys_s, lim_s} = sync2_reg;

  // ----------------------------------------
  // Overcurrent deglitch
  // ----------------------------------------
  logic oc_filt; // Deglitched overcurrent

  hsf_deglitch hsf_deglitch_inst (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_raw(oc_s),
    .o_filt(oc_filt)
  );

  // ----------------------------------------
  // Thermal comparators
  // ----------------------------------------
  logic abs_over;                       // Junction above absolute limit
  logic rel_over;                       // Gradient above relative limit
  logic [hsf_pkg::TEMP_W:0] diff;       // Signed-safe difference
  logic [hsf_pkg::TEMP_W:0] clear_pt;   // Temperature at which absolute fault clears

  always_comb begin
    diff = {1'b0, tj_s} - {1'b0, tc_s};
    abs_over = tj_s > tabs_s;
    rel_over = (tj_s > tc_s) && (diff > {1'b0, trel_s});
    clear_pt = {1'b0, tabs_s} - {1'b0, thys_s};
  end

  // ----------------------------------------
  // Fault state machine
  // ----------------------------------------
  hsf_pkg::hsf_state_t state_reg, state_next;
  logic fault_reg, fault_next;        // Fault state flag for the pin
  logic abs_flt_reg, abs_flt_next;    // Latched absolute thermal fault
  logic rel_flt_reg, rel_flt_next;    // Latched relative thermal fault
  logic oc_flt_reg, oc_flt_next;      // Latched current limit fault
  logic [hsf_pkg::CNT_W-1:0] retry_reg, retry_next; // Retry countdown
  logic [2:0] cnt_reg, cnt_next;      // Consecutive fault count
  logic fold_reg, fold_next;          // Halved limit active
  logic clean_reg, clean_next;        // On period had no fault
  logic gate_reg, gate_next;
  logic [1:0] sns_reg, sns_next;
  logic [hsf_pkg::LIM_W-1:0] lim_reg, lim_next;
  logic trip;                         // Any protection trips now
  logic retry_done;

  // Next-state logic for the whole controller
  always_comb begin
    state_next = state_reg;
    abs_flt_next = abs_flt_reg;
    rel_flt_next = rel_flt_reg;
    oc_flt_next = oc_flt_reg;
    retry_next = retry_reg;
    cnt_next = cnt_reg;
    fold_next = fold_reg;
    clean_next = clean_reg;
    retry_done = (retry_reg == '0);
    // current limit acts on filtered flag at once
    trip = abs_over || rel_over || oc_filt;
    if (abs_flt_reg && ({1'b0, tj_s} <= clear_pt)) begin
      abs_flt_next = 1'b0;
    end
    // relative fault clears on retry expiry
    if (rel_flt_reg && retry_done) begin
      rel_flt_next = 1'b0;
    end
    // Current fault clears when comparator drops
    if (oc_flt_reg && !oc_filt) begin
      oc_flt_next = 1'b0;
    end
    if (retry_reg != '0) begin
      retry_next = retry_reg - 1'b1;
    end
    case (state_reg)
      hsf_pkg::HSF_STANDBY: begin
        cnt_next = '0;
        fold_next = 1'b0;
        if (en_s) begin
          state_next = hsf_pkg::HSF_ON;
          clean_next = 1'b1;
        end
      end
      hsf_pkg::HSF_ON: begin
        if (trip) begin
          state_next = hsf_pkg::HSF_FAULT;
          abs_flt_next = abs_over;
          rel_flt_next = rel_over;
          oc_flt_next = oc_filt;
          // timer and count start on entry
          retry_next = hsf_pkg::CNT_W'(RETRY_CYC);
          if (cnt_reg != hsf_pkg::FOLD_COUNT) begin
            cnt_next = cnt_reg + 3'h1;
          end
          // halve after seven faults in a row
          if (FOLDBACK && (cnt_reg + 3'h1 == hsf_pkg::FOLD_COUNT)) begin
            fold_next = 1'b1;
          end
          clean_next = 1'b0;
        end else if (!en_s) begin
          state_next = hsf_pkg::HSF_STANDBY;
          if (clean_reg) begin
            cnt_next = '0;
            fold_next = 1'b0;
          end
        end
      end
      hsf_pkg::HSF_FAULT: begin
        // release needs hold low, expiry, all clear
        // controller sets latch behaviour via hold
        if (!hold_s && retry_done && !abs_flt_next && !rel_flt_next && !oc_flt_next && !trip) begin
          state_next = en_s ? hsf_pkg::HSF_ON : hsf_pkg::HSF_STANDBY;
        end
      end
      default: begin
        state_next = hsf_pkg::HSF_STANDBY;
      end
    endcase
    gate_next = (state_next == hsf_pkg::HSF_ON);
    // Registered copy so the fault pin comes straight from a flop
    fault_next = (state_next == hsf_pkg::HSF_FAULT);
    // fixed fault current on sense output
    if (state_next == hsf_pkg::HSF_FAULT) begin
      sns_next = hsf_pkg::SNS_FAULT;
    end else if (state_next == hsf_pkg::HSF_ON) begin
      sns_next = hsf_pkg::SNS_MEASURE;
    end else begin
      sns_next = hsf_pkg::SNS_OFF;
    end
    lim_next = fold_next ? (lim_s >> 1) : lim_s;
  end

  // Register stage
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_reg <= hsf_pkg::HSF_STANDBY;
      abs_flt_reg <= 1'b0;
      rel_flt_reg <= 1'b0;
      oc_flt_reg <= 1'b0;
      retry_reg <= '0;
      cnt_reg <= '0;
      fold_reg <= 1'b0;
      clean_reg <= 1'b0;
      gate_reg <= 1'b0;
      fault_reg <= 1'b0;
      sns_reg <= hsf_pkg::SNS_OFF;
      lim_reg <= '0;
    end else begin
      state_reg <= state_next;
      abs_flt_reg <= abs_flt_next;
      rel_flt_reg <= rel_flt_next;
      oc_flt_reg <= oc_flt_next;
      retry_reg <= retry_next;
      cnt_reg <= cnt_next;
      fold_reg <= fold_next;
      clean_reg <= clean_next;
      gate_reg <= gate_next;
      fault_reg <= fault_next;
      sns_reg <= sns_next;
      lim_reg <= lim_next;
    end
  end

  // ----------------------------------------
  // Outputs, all from flip-flops
  // ----------------------------------------
  assign o_gate_on = gate_reg;
  assign o_sense_output = sns_reg;
  assign o_current_limit_threshold = lim_reg;
  assign o_fault = fault_reg;
  assign o_foldback = fold_reg;

endmodule : hsf_fault_ctrl

// ===== hsf_pkg.sv
// Constants and types of the high-side switch fault controller.
// Assumes a 250 MHz core clock and digital comparator flags from the analog front end.
// Summary of operation
// - Either protection switches output stage off
// - Fault state keeps output off
// - Fault state drives fixed fault sense current
// - Release needs hold low, retry expired, clear
// - Thermal fault on absolute or relative excess
// - Absolute fault clears after hysteresis drop
// - Relative fault clears when retry expires
// - Current limit switches off without extra delay
// - Overcurrent registered after fixed deglitch time
// - Foldback halves limit after seven faults
// - Standby or clean cycle restores limit
// - Non-foldback variant never reduces limit
package hsf_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ = 250;          // Core clock rate
  localparam int DEGLITCH_NS = 3000;     // Overcurrent deglitch time
  localparam int DEGLITCH_CYC = (DEGLITCH_NS * CLK_MHZ + 999) / 1000;
  localparam int RETRY_US = 2000;        // Retry interval, plain default
  localparam int RETRY_CYC = RETRY_US * CLK_MHZ;
  localparam int CNT_W = 32;             // Width of the retry counter
  localparam int DG_W = 10;              // Width of the deglitch counter

  // ----------------------------------------
  // Foldback and temperature
  // ----------------------------------------
  localparam logic [2:0] FOLD_COUNT = 3'h7;   // Faults in a row before halving
  localparam int TEMP_W = 8;                  // Temperature code width
  localparam int LIM_W = 8;                   // Current limit code width

  // ----------------------------------------
  // Sense output selection
  // ----------------------------------------
  localparam logic [1:0] SNS_MEASURE = 2'h0;  // Normal measurement
  localparam logic [1:0] SNS_FAULT = 2'h1;    // Fault indication current
  localparam logic [1:0] SNS_OFF = 2'h2;      // Diagnostics disabled

  // Main state machine
  typedef enum logic [1:0] {HSF_STANDBY, HSF_ON, HSF_FAULT} hsf_state_t;

endpackage : hsf_pkg

// ===== hsf_deglitch.sv
// Deglitch filter for one comparator flag.
// Assumes the input is already synchronous to i_clk.
`timescale 1ns/1ps
module hsf_deglitch (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Raw and filtered flag
  input wire logic i_raw,
  output logic o_filt
);

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  logic [hsf_pkg::DG_W-1:0] cnt_reg, cnt_next; // Cycles the flag has held
  logic filt_reg, filt_next;                    // Filtered output

  // Count while high, restart on any low cycle
  always_comb begin
    cnt_next = cnt_reg;
    filt_next = 1'b0;
    if (!i_raw) begin
      cnt_next = '0;
    end else if (cnt_reg >= hsf_pkg::DG_W'(hsf_pkg::DEGLITCH_CYC - 1)) begin
      filt_next = 1'b1;
    end else begin
      cnt_next = cnt_reg + 1'b1;
    end
  end

  // Register stage
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_reg <= '0;
      filt_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      filt_reg <= filt_next;
    end
  end

  assign o_filt = filt_reg;

endmodule : hsf_deglitch

// ===== hsf_mcu_model.sv
// Controller-side model that drives the enable and hold pins.
// Assumes bench commands change only at rising edges.
`timescale 1ns/1ps
module hsf_mcu_model (
  // Clock
  input wire logic i_clk,
  // Bench commands
  input wire logic i_cmd_on,
  input wire logic i_cmd_latch,
  // Pins toward the switch
  output logic o_enable = 1'b0,
  output logic o_hold = 1'b0
);
  always @(posedge i_clk) begin
    o_enable <= i_cmd_on;
    o_hold <= i_cmd_latch;
  end
endmodule : hsf_mcu_model

// ===== hsf_fault_ctrl_monitor.sv
// Checker for the fault controller, bound to every instance.
// Assumes the limit setting and temperatures are steady levels.
`timescale 1ns/1ps
module hsf_fault_ctrl_monitor #(
  parameter int RETRY_CYC = 20,
  parameter bit FOLDBACK = 1'b1
) (
  // Clock, reset, pins
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_enable,
  input wire logic i_hold,
  // Analog front end
  input wire logic [7:0] i_transistor_junction_temp,
  input wire logic [7:0] i_controller_temp,
  input wire logic [7:0] i_absolute_temp_limit,
  input wire logic [7:0] i_relative_temp_limit,
  input wire logic [7:0] i_thermal_hysteresis,
  input wire logic i_overcurrent,
  input wire logic [7:0] i_current_limit_setting,
  // Outputs
  input wire logic o_gate_on,
  input wire logic [1:0] o_sense_output,
  input wire logic [7:0] o_current_limit_threshold,
  input wire logic o_fault,
  input wire logic o_foldback
);
  localparam int DG = hsf_pkg::DEGLITCH_CYC;
  localparam int OC_OFF = hsf_pkg::DEGLITCH_CYC + 6; // Sync and state slack
  int fc_reg, fc_next, oc_reg, oc_next; // Fault span, overcurrent run
  logic [3:0] nf_reg, nf_next; // Fault entries since a clean cycle
  logic fd_reg, gd_reg; // Last fault and gate
  logic hot; // Thermal trip condition
  assign hot = i_transistor_junction_temp > i_absolute_temp_limit ||
    (i_transistor_junction_temp > i_controller_temp &&
     i_transistor_junction_temp - i_controller_temp > i_relative_temp_limit);
  // Next counts; a clean gate fall clears the entry count
  always_comb begin
    fc_next = o_fault ? fc_reg + 1 : 0;
    oc_next = i_overcurrent ? oc_reg + 1 : 0;
    nf_next = nf_reg;
    if (o_fault && !fd_reg) nf_next = nf_reg + 4'h1;
    else if (gd_reg && !o_gate_on && !o_fault) nf_next = 4'h0;
  end
  // Count registers
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      fc_reg <= 0;
      oc_reg <= 0;
      nf_reg <= 4'h0;
      fd_reg <= 1'b0;
      gd_reg <= 1'b0;
    end else begin
      fc_reg <= fc_next;
      oc_reg <= oc_next;
      nf_reg <= nf_next;
      fd_reg <= o_fault;
      gd_reg <= o_gate_on;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  chk_fault_gate_off: assert property (o_fault |-> !o_gate_on)
    else $error("gate on in fault");
  chk_fault_sense: assert property (o_fault |-> o_sense_output == hsf_pkg::SNS_FAULT)
    else $error("no fault indication");
  chk_hold_latch: assert property ((o_fault && i_hold) [*4] |=> o_fault)
    else $error("released while held");
  chk_retry_span: assert property ($fell(o_fault) |-> fc_reg >= RETRY_CYC - 1)
    else $error("released before retry");
  chk_thermal_trip: assert property (hot && o_gate_on |-> ##[1:6] o_fault)
    else $error("thermal trip missed");
  chk_deglitch_span: assert property ($rose(o_fault) && i_overcurrent |-> oc_reg >= DG)
    else $error("overcurrent not deglitched");
  chk_oc_off: assert property (oc_reg >= OC_OFF |-> !o_gate_on)
    else $error("overcurrent switch off late");
  chk_limit_value: assert property (o_gate_on |-> o_current_limit_threshold ==
    (o_foldback ? i_current_limit_setting >> 1 : i_current_limit_setting))
    else $error("wrong current limit");
  chk_fold_seven: assert property ($rose(o_foldback) |-> nf_reg inside {4'h6, 4'h7})
    else $error("foldback count wrong");
  chk_no_foldback: assert property (!FOLDBACK |-> !o_foldback)
    else $error("foldback in plain variant");
  chk_standby_restore: assert property ($fell(o_gate_on) && !o_fault |-> ##[1:4] !o_foldback)
    else $error("limit not restored in standby");
endmodule : hsf_fault_ctrl_monitor
bind hsf_fault_ctrl hsf_fault_ctrl_monitor #(.RETRY_CYC(RETRY_CYC), .FOLDBACK(FOLDBACK)) hsf_fault_ctrl_monitor_inst (
  .i_clk, .i_reset_n, .i_enable, .i_hold, .i_transistor_junction_temp, .i_controller_temp,
  .i_absolute_temp_limit, .i_relative_temp_limit, .i_thermal_hysteresis, .i_overcurrent,
  .i_current_limit_setting, .o_gate_on, .o_sense_output, .o_current_limit_threshold, .o_fault, .o_foldback
);

// ===== tb_high_side_switch_fault_control.sv
// Bench for the fault controller: foldback and plain variants side by side.
// Assumes a short retry interval so fault loops stay brief.
`timescale 1ns/1ps
module tb_high_side_switch_fault_control;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic cmd_on = 1'b0;
  logic cmd_latch = 1'b0;
  logic en, hold, oc = 1'b0;
  logic [7:0] tj = 8'h32, ct = 8'h50, lim = 8'h80; // Normal: no thermal trip
  logic [7:0] ab = 8'h64, rl = 8'h1e, hy = 8'h0a;
  logic gate, fault, fold, fold_nf;
  logic [1:0] sense_output;
  logic [7:0] thr, thr_nf;
  int n_mismatch = 0;
  int cmp_count = 0;
  initial forever #2 i_clk = ~i_clk;
  hsf_mcu_model hsf_mcu_model_inst (.i_clk(i_clk), .i_cmd_on(cmd_on), .i_cmd_latch(cmd_latch),
    .o_enable(en), .o_hold(hold));
  hsf_fault_ctrl #(.RETRY_CYC(20), .FOLDBACK(1'b1)) hsf_fault_ctrl_inst (.i_clk(i_clk),
    .i_reset_n(i_reset_n), .i_enable(en), .i_hold(hold), .i_transistor_junction_temp(tj),
    .i_controller_temp(ct), .i_absolute_temp_limit(ab), .i_relative_temp_limit(rl),
    .i_thermal_hysteresis(hy), .i_overcurrent(oc), .i_current_limit_setting(lim), .o_gate_on(gate),
    .o_sense_output(sense_output), .o_current_limit_threshold(thr), .o_fault(fault), .o_foldback(fold));
  // Plain variant sharing all inputs
  hsf_fault_ctrl #(.RETRY_CYC(20), .FOLDBACK(1'b0)) hsf_fault_ctrl_inst_nf (.i_clk(i_clk),
    .i_reset_n(i_reset_n), .i_enable(en), .i_hold(hold), .i_transistor_junction_temp(tj),
    .i_controller_temp(ct), .i_absolute_temp_limit(ab), .i_relative_temp_limit(rl),
    .i_thermal_hysteresis(hy), .i_overcurrent(oc), .i_current_limit_setting(lim), .o_gate_on(),
    .o_sense_output(), .o_current_limit_threshold(thr_nf), .o_fault(), .o_foldback(fold_nf));
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Ends just after an edge so outputs have settled
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : tick
  task automatic wait_fault(input logic v);
    int n;
    n = 0;
    while (fault !== v && n < 900) begin
      tick(1);
      n++;
    end
    chk("fault", 8'(v), 8'(fault));
  endtask : wait_fault
  task automatic t_switch;
    @(posedge i_clk) cmd_on <= 1'b1;
    tick(8);
    chk("gate", 8'h1, 8'(gate));
    chk("sense", 8'(hsf_pkg::SNS_MEASURE), 8'(sense_output));
  endtask : t_switch
  task automatic t_overcurrent;
    @(posedge i_clk) oc <= 1'b1;
    tick(100);
    @(posedge i_clk) oc <= 1'b0;
    tick(20);
    chk("glitch", 8'h0, 8'(fault));
    @(posedge i_clk) cmd_latch <= 1'b1;
    oc <= 1'b1;
    tick(745);
    chk("gate early", 8'h1, 8'(gate));
    tick(15);
    chk("gate off", 8'h0, 8'(gate));
    chk("fault sense", 8'(hsf_pkg::SNS_FAULT), 8'(sense_output));
    @(posedge i_clk) oc <= 1'b0;
    tick(60);
    chk("held", 8'h1, 8'(fault));
    @(posedge i_clk) cmd_latch <= 1'b0;
    wait_fault(1'b0);
    tick(3);
    chk("gate again", 8'h1, 8'(gate));
  endtask : t_overcurrent
  task automatic t_thermal;
    @(posedge i_clk) tj <= ab + 8'h1;
    wait_fault(1'b1);
    @(posedge i_clk) tj <= ab - hy + 8'h1;
    tick(40);
    chk("hysteresis", 8'h1, 8'(fault));
    @(posedge i_clk) tj <= ab - hy;
    wait_fault(1'b0);
    @(posedge i_clk) ct <= 8'h10;
    wait_fault(1'b1);
    @(posedge i_clk) ct <= 8'h50;
    wait_fault(1'b0);
  endtask : t_thermal
  task automatic t_fold;
    @(posedge i_clk) cmd_on <= 1'b0;
    tick(8);
    @(posedge i_clk) cmd_on <= 1'b1;
    tick(8);
    for (int k = 0; k < 7; k++) begin
      chk("no fold", 8'h0, 8'(fold));
      @(posedge i_clk) tj <= ab + 8'h1;
      wait_fault(1'b1);
      @(posedge i_clk) tj <= 8'h32;
      wait_fault(1'b0);
    end
    chk("fold", 8'h1, 8'(fold));
    chk("half limit", lim >> 1, thr);
    chk("plain limit", lim, thr_nf);
    chk("plain fold", 8'h0, 8'(fold_nf));
    @(posedge i_clk) cmd_on <= 1'b0;
    tick(8);
    chk("restored", lim, thr);
    chk("standby sense", 8'(hsf_pkg::SNS_OFF), 8'(sense_output));
  endtask : t_fold
  task automatic end_of_test;
    $display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (4) @(posedge i_clk);
    i_reset_n <= 1'b1;
    tick(4);
    t_switch();
    t_overcurrent();
    t_thermal();
    t_fold();
    end_of_test();
  end
  // Watchdog well past the expected run of under two thousand cycles
  initial begin
    #80000;
    n_mismatch++;
    end_of_test();
  end
endmodule : tb_high_side_switch_fault_control
